// *** design/hpsc_panel_ctrl.sv ***
// How it works
// - 8 MHz processor clock derived from a 16 MHz crystal rate, driven out
// - inverted processor clock driven out; second register bank on its edge
// - three active-low column strobes, each low 2 ms per 6 ms
// - three active-low row strobes, low 2 ms per 6 ms when lit
// - left and right headroom column strobes, 4 ms square waves
// - active-low watchdog kick about 150 ns wide every 1 ms
// - master, slave, effects and dsp resets low at power-up, then high
// - active-low audio mute held at power-up, released in normal running
// - nmi rests low, pulses high on digital io error when enabled
// - soft irq 5 high 10 ms per 20; line 7 high 11 ms per 40
`default_nettype none
module hpsc_panel_ctrl
  import hpsc_pkg::*;
#(
  parameter int unsigned MS_CYC = MS_CYCLES,
  parameter int unsigned HOLD_MS = POWERUP_HOLD_MS,
  parameter int unsigned UNMUTE_MS = MUTE_HOLD_MS
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic [8:0] i_led_pattern,
  input wire logic i_dio_error,
  input wire logic i_digital_io_irq_enable,
  input wire logic i_soft_irq_5_enable,
  input wire logic i_soft_irq_7_enable,
  input wire logic i_adjust_knob_line_a,
  input wire logic i_adjust_knob_line_b,
  input wire logic i_select_knob_line_a,
  input wire logic i_select_knob_line_b,
  output logic o_proc_clk,
  output logic o_proc_clk_n,
  output logic o_proc_rise,
  output logic o_proc_fall,
  output logic o_panel_column_strobe_0_n,
  output logic o_panel_column_strobe_1_n,
  output logic o_panel_column_strobe_2_n,
  output logic o_led_row_strobe_0_n,
  output logic o_led_row_strobe_1_n,
  output logic o_led_row_strobe_2_n,
  output logic o_left_peak_led_col_n,
  output logic o_right_peak_led_col_n,
  output logic o_watchdog_kick_n,
  output logic o_master_reset_n,
  output logic o_slave_cpu_reset_n,
  output logic o_effects_asic_reset_n,
  output logic o_dsp_reset_n,
  output logic o_master_mute_n,
  output logic o_host_nonmaskable_irq,
  output logic o_soft_irq_line_5,
  output logic o_soft_irq_line_7,
  output logic o_adjust_step,
  output logic o_adjust_cw,
  output logic o_select_step,
  output logic o_select_cw,
  output logic o_running
);
  //////////////////////////////////////////////////////////////////////////
  // sized constants
  localparam logic [6:0] ACC_STEP = 7'(XTAL_MHZ);
  localparam logic [6:0] ACC_MOD = 7'(CLK_MHZ);
  localparam logic [3:0] WD_LOAD = 4'(WD_PULSE_CYC);
  localparam logic [5:0] NMI_LOAD = 6'(NMI_PULSE_CYC);
  localparam logic [1:0] COL_LAST = 2'(SCAN_COLS - 1);
  localparam logic [1:0] SLOT_LAST = 2'(SCAN_SLOT_MS - 1);
  localparam logic [1:0] HR_HALF_LAST = 2'(HEADROOM_PERIOD_MS / 2 - 1);
  localparam logic [5:0] IRQ5_LAST = 6'(IRQ5_PERIOD_MS - 1);
  localparam logic [5:0] IRQ5_HIGH = 6'(IRQ5_HIGH_MS);
  localparam logic [5:0] IRQ7_LAST = 6'(IRQ7_PERIOD_MS - 1);
  localparam logic [5:0] IRQ7_HIGH = 6'(IRQ7_HIGH_MS);
  localparam logic [MS_CNT_W-1:0] HOLD_LAST = MS_CNT_W'(HOLD_MS - 1);
  localparam logic [MS_CNT_W-1:0] UNMUTE_LAST = MS_CNT_W'(UNMUTE_MS - 1);
  localparam logic [2:0] ALL_OFF = 3'h7;

  //////////////////////////////////////////////////////////////////////////
  // processor clock from the crystal rate
  logic [6:0] acc;
  logic proc_clk;
  wire [6:0] acc_sum = acc + ACC_STEP;
  // the base clock is not a multiple of 16 MHz, so edges jitter by
  // one base cycle while the average rate stays exact
  wire xtal_tick = (acc_sum >= ACC_MOD);
  wire [6:0] next_acc = xtal_tick ? acc_sum - ACC_MOD : acc_sum;

  // crystal divided by two gives the processor clock
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      acc <= 7'h00;
      proc_clk <= 1'b0;
      o_proc_clk <= 1'b0;
      o_proc_clk_n <= 1'b1;
      o_proc_rise <= 1'b0;
      o_proc_fall <= 1'b0;
    end else begin
      acc <= next_acc;
      if (xtal_tick) begin
        proc_clk <= ~proc_clk;
      end
      o_proc_clk <= proc_clk;
      o_proc_clk_n <= ~proc_clk;
      o_proc_rise <= xtal_tick & ~proc_clk;
      o_proc_fall <= xtal_tick & proc_clk;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // millisecond time base
  logic ms_tick;

  hpsc_tick_div #(
    .CYCLES(MS_CYC)
  ) u_ms_div (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .o_tick(ms_tick)
  );

  //////////////////////////////////////////////////////////////////////////
  // power-up sequencing
  hpsc_pwr_t pwr_state;
  hpsc_pwr_t next_pwr_state;
  logic [MS_CNT_W-1:0] pwr_ms;
  wire hold_done = ms_tick && (pwr_ms == HOLD_LAST);
  wire unmute_done = ms_tick && (pwr_ms == UNMUTE_LAST);
  wire running = (pwr_state == HPSC_PWR_RUN);

  // resets release first; mute lifts once the processors settle
  always_comb begin
    next_pwr_state = pwr_state;
    unique case (pwr_state)
      HPSC_PWR_HOLD: begin
        if (hold_done) begin
          next_pwr_state = HPSC_PWR_UNMUTE;
        end
      end
      HPSC_PWR_UNMUTE: begin
        if (unmute_done) begin
          next_pwr_state = HPSC_PWR_RUN;
        end
      end
      HPSC_PWR_RUN: next_pwr_state = HPSC_PWR_RUN;
      default: next_pwr_state = HPSC_PWR_HOLD;
    endcase
  end

  // state, ms counter and the reset and mute pins
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      pwr_state <= HPSC_PWR_HOLD;
      pwr_ms <= '0;
      o_master_reset_n <= 1'b0;
      o_slave_cpu_reset_n <= 1'b0;
      o_effects_asic_reset_n <= 1'b0;
      o_dsp_reset_n <= 1'b0;
      o_master_mute_n <= 1'b0;
      o_running <= 1'b0;
    end else begin
      pwr_state <= next_pwr_state;
      if (next_pwr_state != pwr_state) begin
        pwr_ms <= '0;
      end else if (ms_tick && !running) begin
        pwr_ms <= pwr_ms + MS_CNT_W'(1);
      end
      o_master_reset_n <= (next_pwr_state != HPSC_PWR_HOLD);
      o_slave_cpu_reset_n <= (next_pwr_state != HPSC_PWR_HOLD);
      o_effects_asic_reset_n <= (next_pwr_state != HPSC_PWR_HOLD);
      o_dsp_reset_n <= (next_pwr_state != HPSC_PWR_HOLD);
      o_master_mute_n <= (next_pwr_state == HPSC_PWR_RUN);
      o_running <= (next_pwr_state == HPSC_PWR_RUN);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // column and row scan
  logic [1:0] slot_ms;
  logic [1:0] col;
  logic [2:0] col_n;
  logic [2:0] row_n;
  wire slot_end = ms_tick && (slot_ms == SLOT_LAST);
  // strobes start on the edge that raises running, so slot zero is full
  wire run_next = (next_pwr_state == HPSC_PWR_RUN);
  wire [1:0] next_col = !running ? 2'h0 :
    !slot_end ? col :
    (col == COL_LAST) ? 2'h0 : col + 2'h1;
  wire [2:0] col_onehot = 3'h1 << next_col;
  wire [2:0] row_lit = (next_col == 2'h0) ? i_led_pattern[2:0] :
    (next_col == 2'h1) ? i_led_pattern[5:3] : i_led_pattern[8:6];

  // strobes stay idle until normal running
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      slot_ms <= 2'h0;
      col <= 2'h0;
      col_n <= ALL_OFF;
      row_n <= ALL_OFF;
    end else begin
      if (!running || slot_end) begin
        slot_ms <= 2'h0;
      end else if (ms_tick) begin
        slot_ms <= slot_ms + 2'h1;
      end
      col <= next_col;
      col_n <= run_next ? ~col_onehot : ALL_OFF;
      row_n <= run_next ? ~row_lit : ALL_OFF;
    end
  end

  assign o_panel_column_strobe_0_n = col_n[0];
  assign o_panel_column_strobe_1_n = col_n[1];
  assign o_panel_column_strobe_2_n = col_n[2];
  assign o_led_row_strobe_0_n = row_n[0];
  assign o_led_row_strobe_1_n = row_n[1];
  assign o_led_row_strobe_2_n = row_n[2];

  //////////////////////////////////////////////////////////////////////////
  // headroom columns, driven in opposite phase to share the rows
  logic [1:0] hr_ms;
  wire hr_flip = ms_tick && (hr_ms == HR_HALF_LAST);

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      hr_ms <= 2'h0;
      o_left_peak_led_col_n <= 1'b1;
      o_right_peak_led_col_n <= 1'b0;
    end else begin
      if (hr_flip) begin
        hr_ms <= 2'h0;
        o_left_peak_led_col_n <= ~o_left_peak_led_col_n;
        o_right_peak_led_col_n <= o_left_peak_led_col_n;
      end else if (ms_tick) begin
        hr_ms <= hr_ms + 2'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // watchdog kick, one per ms while running
  logic [3:0] wd_cnt;
  wire wd_start = ms_tick && running;

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      wd_cnt <= 4'h0;
      o_watchdog_kick_n <= 1'b1;
    end else if (wd_start) begin
      wd_cnt <= WD_LOAD;
      o_watchdog_kick_n <= 1'b0;
    end else if (wd_cnt != 4'h0) begin
      wd_cnt <= wd_cnt - 4'h1;
      if (wd_cnt == 4'h1) begin
        o_watchdog_kick_n <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // digital io error into nmi
  logic err_sync1;
  logic err_sync2;
  logic err_now;
  logic err_prev;
  logic [5:0] nmi_cnt;
  // edge seen by the bank clocked on the inverted processor clock
  wire err_rise = err_now & ~err_prev;
  wire nmi_start = err_rise && i_digital_io_irq_enable;

  // the error pin is asynchronous: two flops first
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      err_sync1 <= 1'b0;
      err_sync2 <= 1'b0;
    end else begin
      err_sync1 <= i_dio_error;
      err_sync2 <= err_sync1;
    end
  end

  // second bank, advanced only on the inverted clock edge
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      err_now <= 1'b0;
      err_prev <= 1'b0;
    end else if (o_proc_fall) begin
      err_now <= err_sync2;
      err_prev <= err_now;
    end
  end

  // a long error makes one pulse, not a level
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      nmi_cnt <= 6'h00;
      o_host_nonmaskable_irq <= 1'b0;
    end else if (nmi_start && o_proc_fall) begin
      nmi_cnt <= NMI_LOAD;
      o_host_nonmaskable_irq <= 1'b1;
    end else if (nmi_cnt != 6'h00) begin
      nmi_cnt <= nmi_cnt - 6'h01;
      if (nmi_cnt == 6'h01) begin
        o_host_nonmaskable_irq <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // programmable interrupt lines
  logic [5:0] irq5_ms;
  logic [5:0] irq7_ms;
  wire [5:0] next_irq5_ms = !running ? 6'h00 : !ms_tick ? irq5_ms :
    (irq5_ms == IRQ5_LAST) ? 6'h00 : irq5_ms + 6'h01;
  wire [5:0] next_irq7_ms = !running ? 6'h00 : !ms_tick ? irq7_ms :
    (irq7_ms == IRQ7_LAST) ? 6'h00 : irq7_ms + 6'h01;

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      irq5_ms <= 6'h00;
      irq7_ms <= 6'h00;
      o_soft_irq_line_5 <= 1'b0;
      o_soft_irq_line_7 <= 1'b0;
    end else begin
      irq5_ms <= next_irq5_ms;
      irq7_ms <= next_irq7_ms;
      o_soft_irq_line_5 <= running && i_soft_irq_5_enable &&
        (next_irq5_ms < IRQ5_HIGH);
      o_soft_irq_line_7 <= running && i_soft_irq_7_enable &&
        (next_irq7_ms < IRQ7_HIGH);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // soft knobs
  hpsc_quad_dec u_adjust_dec (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_line_a(i_adjust_knob_line_a),
    .i_line_b(i_adjust_knob_line_b),
    .o_step(o_adjust_step),
    .o_cw(o_adjust_cw)
  );

  hpsc_quad_dec u_select_dec (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_line_a(i_select_knob_line_a),
    .i_line_b(i_select_knob_line_b),
    .o_step(o_select_step),
    .o_cw(o_select_cw)
  );
endmodule
`default_nettype wire

// *** design/hpsc_pkg.sv ***
`default_nettype none
package hpsc_pkg;
  // base clock
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned HZ_PER_MHZ = 1_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned CLK_MHZ = CLK_HZ / HZ_PER_MHZ;
  localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;

  // crystal and processor clock
  localparam int unsigned XTAL_HZ = 16_000_000;
  localparam int unsigned PROC_CLK_HZ = 8_000_000;
  localparam int unsigned XTAL_MHZ = XTAL_HZ / HZ_PER_MHZ;

  // watchdog kick, least width rounds up
  localparam int unsigned WD_PULSE_NS = 150;
  localparam int unsigned WD_PULSE_CYC =
    (WD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WD_PERIOD_MS = 1;

  // nmi pulse width
  localparam int unsigned NMI_PULSE_NS = 500;
  localparam int unsigned NMI_PULSE_CYC =
    (NMI_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // panel scan
  localparam int unsigned SCAN_COLS = 3;
  localparam int unsigned SCAN_ROWS = 3;
  localparam int unsigned SCAN_SLOT_MS = 2;
  localparam int unsigned HEADROOM_PERIOD_MS = 4;

  // software interrupt lines
  localparam int unsigned IRQ5_HIGH_MS = 10;
  localparam int unsigned IRQ5_PERIOD_MS = 20;
  localparam int unsigned IRQ7_HIGH_MS = 11;
  localparam int unsigned IRQ7_PERIOD_MS = 40;

  // power-up sequencing defaults
  localparam int unsigned POWERUP_HOLD_MS = 100;
  localparam int unsigned MUTE_HOLD_MS = 50;
  localparam int unsigned MS_CNT_W = 8;

  // quadrature positions along clockwise travel, {b,a}
  localparam logic [1:0] QUAD_BA_POS0 = 2'h3;
  localparam logic [1:0] QUAD_BA_POS1 = 2'h2;
  localparam logic [1:0] QUAD_BA_POS2 = 2'h0;
  localparam logic [1:0] QUAD_BA_POS3 = 2'h1;

  typedef enum logic [1:0] {
    HPSC_PWR_HOLD = 2'h0,
    HPSC_PWR_UNMUTE = 2'h1,
    HPSC_PWR_RUN = 2'h3
  } hpsc_pwr_t;
endpackage
`default_nettype wire

// *** design/hpsc_tick_div.sv ***
`default_nettype none
module hpsc_tick_div #(
  parameter int unsigned CYCLES = 50000
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  output logic o_tick
);
  localparam int unsigned W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] count;
  wire at_last = (count == LAST);

  // free-running divider, one-cycle pulse per wrap
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      count <= '0;
      o_tick <= 1'b0;
    end else begin
      count <= at_last ? '0 : count + W'(1);
      o_tick <= at_last;
    end
  end
endmodule
`default_nettype wire

// *** design/hpsc_quad_dec.sv ***
`default_nettype none
module hpsc_quad_dec
  import hpsc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_line_a,
  input wire logic i_line_b,
  output logic o_step,
  output logic o_cw
);
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [1:0] prev;

  // position of a {b,a} pattern along clockwise travel
  function automatic logic [1:0] pos_of(input logic [1:0] ba);
    logic [1:0] p;
    p = 2'h0;
    unique case (ba)
      QUAD_BA_POS0: p = 2'h0;
      QUAD_BA_POS1: p = 2'h1;
      QUAD_BA_POS2: p = 2'h2;
      QUAD_BA_POS3: p = 2'h3;
    endcase
    return p;
  endfunction

  wire [1:0] cur_pos = pos_of(sync2);
  wire [1:0] prev_pos = pos_of(prev);
  // a double jump is ambiguous and dropped
  wire step_cw = (cur_pos == prev_pos + 2'h1);
  wire step_ccw = (prev_pos == cur_pos + 2'h1);

  // pins are asynchronous: two flops before decode
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      sync1 <= 2'h3;
      sync2 <= 2'h3;
      prev <= 2'h3;
      o_step <= 1'b0;
      o_cw <= 1'b0;
    end else begin
      sync1 <= {i_line_b, i_line_a};
      sync2 <= sync1;
      prev <= sync2;
      o_step <= step_cw | step_ccw;
      if (step_cw | step_ccw) begin
        o_cw <= step_cw;
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/hpsc_panel_ctrl_chk.sv ***
`default_nettype none
module hpsc_panel_ctrl_chk (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic o_proc_clk,
  input wire logic o_proc_clk_n,
  input wire logic o_proc_rise,
  input wire logic o_panel_column_strobe_0_n,
  input wire logic o_panel_column_strobe_1_n,
  input wire logic o_panel_column_strobe_2_n,
  input wire logic o_led_row_strobe_0_n,
  input wire logic o_led_row_strobe_1_n,
  input wire logic o_led_row_strobe_2_n,
  input wire logic o_left_peak_led_col_n,
  input wire logic o_right_peak_led_col_n,
  input wire logic o_watchdog_kick_n,
  input wire logic o_master_reset_n,
  input wire logic o_slave_cpu_reset_n,
  input wire logic o_effects_asic_reset_n,
  input wire logic o_dsp_reset_n,
  input wire logic o_master_mute_n,
  input wire logic o_host_nonmaskable_irq,
  input wire logic o_soft_irq_line_5,
  input wire logic o_soft_irq_line_7,
  input wire logic o_running
);
  timeunit 1ns;
  timeprecision 100ps;
  // short views of the strobe groups
  wire logic [2:0] col = {o_panel_column_strobe_2_n,
    o_panel_column_strobe_1_n, o_panel_column_strobe_0_n};
  wire logic [2:0] row = {o_led_row_strobe_2_n,
    o_led_row_strobe_1_n, o_led_row_strobe_0_n};
  wire logic kick = o_watchdog_kick_n;
  wire logic nmi = o_host_nonmaskable_irq;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  ////////////////////////////////////////////////////////////////////////
  a_clk_inverse: assert property (o_proc_clk_n == !o_proc_clk)
    else $error("inverted processor clock is not the inverse");
  // 50 MHz cannot divide evenly, so half periods are 3 or 4 cycles
  a_clk_half: assert property ($changed(o_proc_clk) |=>
    $stable(o_proc_clk) [*2] ##[1:2] $changed(o_proc_clk))
    else $error("processor clock half period out of range");
  // the rise pulse leads the registered clock pin by one cycle
  a_rise_align: assert property (o_proc_rise |=> $rose(o_proc_clk))
    else $error("rise pulse not aligned with clock edge");
  a_resets_tied: assert property ({o_slave_cpu_reset_n,
    o_effects_asic_reset_n, o_dsp_reset_n} == {3{o_master_reset_n}})
    else $error("reset outputs disagree");
  a_mute_order: assert property (o_master_mute_n |->
    o_master_reset_n && o_running)
    else $error("mute released before resets or running");
  a_idle_dark: assert property (!o_running |->
    col == 3'h7 && row == 3'h7 && !o_soft_irq_line_5 &&
    !o_soft_irq_line_7 && kick)
    else $error("panel or irq activity before running");
  a_one_column: assert property (o_running |-> $countones(col) == 2)
    else $error("not exactly one column strobe active");
  a_col_order: assert property ($fell(col[1]) |-> $rose(col[0]))
    else $error("column one did not follow column zero");
  a_peak_compl: assert property (o_left_peak_led_col_n !=
    o_right_peak_led_col_n)
    else $error("headroom columns not in opposite phase");
  a_kick_width: assert property ($fell(kick) |->
    !kick [*8] ##1 kick)
    else $error("watchdog kick width is not 8 cycles");
  a_nmi_hold: assert property ($rose(nmi) |-> nmi [*8])
    else $error("nmi pulse collapsed early");
  c_nmi: cover property ($rose(nmi));
  c_kick: cover property ($fell(kick));
  c_col2: cover property ($fell(col[2]));
endmodule
bind hpsc_panel_ctrl hpsc_panel_ctrl_chk u_chk (.i_ref_clk, .i_reset_n,
  .o_proc_clk, .o_proc_clk_n, .o_proc_rise, .o_panel_column_strobe_0_n,
  .o_panel_column_strobe_1_n, .o_panel_column_strobe_2_n,
  .o_led_row_strobe_0_n, .o_led_row_strobe_1_n, .o_led_row_strobe_2_n,
  .o_left_peak_led_col_n, .o_right_peak_led_col_n, .o_watchdog_kick_n,
  .o_master_reset_n, .o_slave_cpu_reset_n, .o_effects_asic_reset_n,
  .o_dsp_reset_n, .o_master_mute_n, .o_host_nonmaskable_irq,
  .o_soft_irq_line_5, .o_soft_irq_line_7, .o_running);
`default_nettype wire

// *** verif/hpsc_knob_model.sv ***
`default_nettype none
module hpsc_knob_model
  import hpsc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_move,
  input wire logic i_cw,
  output logic o_line_a,
  output logic o_line_b
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] pos = 2'h0;
  logic [1:0] ba;
  // detent table in clockwise order; contacts never jump two codes
  always_comb begin
    case (pos)
      2'h0: ba = QUAD_BA_POS0;
      2'h1: ba = QUAD_BA_POS1;
      2'h2: ba = QUAD_BA_POS2;
      default: ba = QUAD_BA_POS3;
    endcase
  end
  // one detent per request, direction chosen by the bench
  always @(posedge i_ref_clk) begin
    if (i_move) begin
      pos <= i_cw ? pos + 2'h1 : pos - 2'h1;
    end
  end
  assign o_line_b = ba[1];
  assign o_line_a = ba[0];
endmodule
`default_nettype wire

// *** verif/hpsc_panel_ctrl_test.sv ***
`default_nettype none
module hpsc_panel_ctrl_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int MS = 20;
  localparam int HI_X[5] = '{0, 2 * MS, 8, 10 * MS, 11 * MS};
  localparam int PER_X[5] = '{0, 4 * MS, MS, 20 * MS, 40 * MS};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [8:0] pat = 9'h000;
  logic err = 1'b0, nmi_en = 1'b0, e5 = 1'b0, e7 = 1'b0;
  logic am = 1'b0, acw = 1'b0, sm = 1'b0, scw = 1'b0, nmi_q = 1'b0;
  logic aa, ab, sa, sb, pclk, pclk_n, prise, c0, c1, c2, r0, r1, r2;
  logic lp, rp, kick, mr, sr, er, dr, mute, nmi, i5, i7, run;
  logic astep, acwo, sstep, scwo;
  int err_count = 0, cmp_count = 0, cyc = 0, nmis = 0;
  int asteps = 0, ssteps = 0, rises = 0;
  always #10 clk = ~clk;
  hpsc_panel_ctrl #(.MS_CYC(MS), .HOLD_MS(2), .UNMUTE_MS(1)) dut (
    .i_ref_clk(clk), .i_reset_n(rst_n), .i_led_pattern(pat),
    .i_dio_error(err), .i_digital_io_irq_enable(nmi_en),
    .i_soft_irq_5_enable(e5), .i_soft_irq_7_enable(e7),
    .i_adjust_knob_line_a(aa), .i_adjust_knob_line_b(ab),
    .i_select_knob_line_a(sa), .i_select_knob_line_b(sb),
    .o_proc_clk(pclk), .o_proc_clk_n(pclk_n), .o_proc_rise(prise),
    .o_proc_fall(), .o_panel_column_strobe_0_n(c0),
    .o_panel_column_strobe_1_n(c1), .o_panel_column_strobe_2_n(c2),
    .o_led_row_strobe_0_n(r0), .o_led_row_strobe_1_n(r1),
    .o_led_row_strobe_2_n(r2), .o_left_peak_led_col_n(lp),
    .o_right_peak_led_col_n(rp), .o_watchdog_kick_n(kick),
    .o_master_reset_n(mr), .o_slave_cpu_reset_n(sr),
    .o_effects_asic_reset_n(er), .o_dsp_reset_n(dr),
    .o_master_mute_n(mute), .o_host_nonmaskable_irq(nmi),
    .o_soft_irq_line_5(i5), .o_soft_irq_line_7(i7),
    .o_adjust_step(astep), .o_adjust_cw(acwo), .o_select_step(sstep),
    .o_select_cw(scwo), .o_running(run));
  hpsc_knob_model u_adj (.i_ref_clk(clk), .i_move(am), .i_cw(acw),
    .o_line_a(aa), .o_line_b(ab));
  hpsc_knob_model u_sel (.i_ref_clk(clk), .i_move(sm), .i_cw(scw),
    .o_line_a(sa), .o_line_b(sb));
  ////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // event counters and the hang guard
  always @(posedge clk) begin
    nmi_q <= nmi;
    cyc <= cyc + 1;
    if (nmi === 1'b1 && nmi_q === 1'b0) nmis <= nmis + 1;
    if (astep === 1'b1) asteps <= asteps + 1;
    if (sstep === 1'b1) ssteps <= ssteps + 1;
    if (prise === 1'b1) rises <= rises + 1;
    if (cyc == 20000) begin
      err_count++;
      $display("CHECK FAILED timeout exp 0 seen %0d", cyc);
      close_out();
    end
  end
  // inputs move 1 ns after the edge so outputs are settled when read
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s exp %0h seen %0h", what, exp, seen);
    end
  endtask
  function automatic logic sig(input int s);
    case (s)
      1: return !lp;
      2: return !kick;
      3: return i5;
      4: return i7;
      default: return nmi;
    endcase
  endfunction
  function automatic int col_idx();
    return c0 === 1'b0 ? 0 : c1 === 1'b0 ? 1 : c2 === 1'b0 ? 2 : 3;
  endfunction
  // skips a pulse already under way, then times width, and period for s below 5
  task automatic measure(input int s, output int hi, output int per);
    int n;
    n = 0;
    while (sig(s) === 1'b1 && n < 2000) begin
      tick(1);
      n++;
    end
    while (sig(s) !== 1'b1 && n < 4000) begin
      tick(1);
      n++;
    end
    hi = 0;
    while (sig(s) === 1'b1 && hi < 2000) begin
      tick(1);
      hi++;
    end
    per = hi;
    while (sig(s) !== 1'b1 && per < 2000 && s < 5) begin
      tick(1);
      per++;
    end
  endtask
  task automatic wait_slot(output int n);
    logic [2:0] v;
    v = {c2, c1, c0};
    n = 0;
    while ({c2, c1, c0} === v && n < 200) begin
      tick(1);
      n++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    int hi, per, c, cp, n;
    void'($urandom(32'h573EAA1B));
    tick(16);
    rst_n = 1'b1;
    tick(30);
    check("resets", {mr, sr, er, dr}, 4'h0);
    check("mute", mute, 1'b0);
    tick(20);
    check("resets", {mr, sr, er, dr}, 4'hF);
    check("mute", mute, 1'b0);
    tick(20);
    check("mute run", {mute, run}, 2'h3);
    $display("test power-up done");
    // all-lit and all-dark slots first, then random patterns
    wait_slot(n);
    for (int i = 0; i < 7; i++) begin
      pat = i == 0 ? 9'h1FF : i == 1 ? 9'h000 : 9'($urandom);
      cp = col_idx();
      tick(3);
      check("rows", {r2, r1, r0}, 3'(~pat[cp * 3 +: 3]));
      wait_slot(n);
      check("slot", n + 3, 2 * MS);
      c = col_idx();
      check("rotation", c, (cp + 1) % 3);
    end
    $display("test scan done");
    e5 = 1'b1;
    e7 = 1'b1;
    for (int s = 1; s < 5; s++) begin
      measure(s, hi, per);
      check("width", hi, HI_X[s]);
      check("period", per, PER_X[s]);
    end
    e5 = 1'b0;
    tick(MS);
    check("irq5 gated", i5, 1'b0);
    $display("test periodic done");
    nmi_en = 1'b1;
    err = 1'b1;
    measure(5, hi, per);
    check("nmi width", hi, 25);
    err = 1'b0;
    nmi_en = 1'b0;
    tick(20);
    n = nmis;
    err = 1'b1;
    tick(40);
    check("nmi gated", nmis - n, 0);
    $display("test nmi done");
    for (int i = 0; i < 8; i++) begin
      n = asteps;
      cp = ssteps;
      acw = 1'($urandom);
      scw = 1'($urandom);
      am = 1'b1;
      sm = 1'b1;
      tick(1);
      am = 1'b0;
      sm = 1'b0;
      tick(8);
      check("adj step", asteps - n, 1);
      check("adj dir", acwo, acw);
      check("sel step", ssteps - cp, 1);
      check("sel dir", scwo, scw);
    end
    $display("test knobs done");
    n = rises;
    tick(500);
    check("proc clk", (rises - n) inside {[79:81]}, 1'b1);
    rst_n = 1'b0;
    tick(2);
    check("reset again", {mr, mute, run, c0, c1, c2}, 6'h07);
    $display("test clock and reset done");
    close_out();
  end
endmodule
`default_nettype wire
